/* src/ecl_map.vh */
// register map, field positions, reset values and load sequencing constants
`ifndef ECL_MAP_VH
`define ECL_MAP_VH
`define ECL_ADDR_W 16
`define ECL_GIS_ADDR 16'h021f
`define ECL_GIS_CRC_OK_BIT 0
`define ECL_GIS_RESERVED 8'h00
`define ECL_MODE_ADDR 16'h0000
`define ECL_MODE_SYNTH 8'h00
`define ECL_MODE_REFSEL 8'h01
`define ECL_MEM_AW 6
`define ECL_MEM_DEPTH 64
`define ECL_REG_RESET 8'h00
`define ECL_OTP_WORDS 7'h40
`define ECL_EEP_WORDS 7'h40
`endif

/* src/ecl_regmem.v */
// configuration register memory with registered read data
`include "ecl_map.vh"
module ecl_regmem (
    // clock
    input wire clock,
    // write port
    input wire wr_en,
    input wire [`ECL_MEM_AW-1:0] wr_addr,
    input wire [7:0] wr_data,
    // read port
    input wire [`ECL_MEM_AW-1:0] rd_addr,
    output reg [7:0] rd_data
);
    reg [7:0] mem [0:`ECL_MEM_DEPTH-1];
    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* src/ecl_loader.v */
// power-up configuration loader with eeprom crc fault handling of the serial port
// Function
// - after eeprom crc failure, serial writes are not completed until reset
// - in failed state every read returns zero; only hardware reset clears it
// - serial port works normally without eeprom load, eeprom absent, or crc pass
// - active-high crc ok flag in global interrupt status register at 21fh
// - otp load still applies its settings despite an eeprom crc failure
// - default power-up runs synthesizer mode from crystal, ignoring reference inputs
`include "ecl_map.vh"
module ecl_loader (
    // clock and reset
    input wire clock,
    input wire rstn,
    // hardware reset pin, synchronous
    input wire device_reset_in_n,
    // load options
    input wire otp_load_en,
    input wire eeprom_load_en,
    // otp source
    output reg otp_rd,
    output reg [`ECL_MEM_AW-1:0] otp_addr,
    input wire [7:0] otp_data,
    // eeprom link
    output reg eep_rd,
    output reg [`ECL_MEM_AW-1:0] eep_addr,
    input wire eep_present,
    input wire [7:0] eep_data,
    input wire eep_done,
    input wire eep_crc_pass,
    // serial port
    input wire sp_wr,
    input wire sp_rd,
    input wire [`ECL_ADDR_W-1:0] sp_addr,
    input wire [7:0] sp_wdata,
    output reg sp_wr_ack,
    output reg sp_rd_valid,
    output reg [7:0] sp_rdata,
    // status
    output reg load_busy,
    output reg eeprom_crc_ok_n,
    output reg synth_mode
);
    localparam ST_OTP = 4'b0001;
    localparam ST_EEP = 4'b0010;
    localparam ST_WAIT = 4'b0100;
    localparam ST_RUN = 4'b1000;

    reg [3:0] state;
    reg [6:0] cnt;
    reg crc_fail;
    reg otp_vld;
    reg eep_vld;
    reg rd_pend;
    reg rd_gis;
    reg [7:0] gis;
    reg [`ECL_MEM_AW-1:0] ld_wa;
    reg rd_hit;
    wire [7:0] mem_q;
    wire soft_rst;
    wire sp_mem_hit;
    wire mem_we;
    wire [`ECL_MEM_AW-1:0] mem_wa;
    wire [7:0] mem_wd;
    wire next_crc_fail;

    assign soft_rst = !device_reset_in_n;
    assign sp_mem_hit = (sp_addr[`ECL_ADDR_W-1:`ECL_MEM_AW] == 10'h000);
    // loader writes while loading; serial writes only when running and healthy
    assign mem_we = otp_vld | eep_vld | ((state == ST_RUN) & sp_wr & !crc_fail & sp_mem_hit & !soft_rst);
    // loader words go to the address of the read whose data arrives now
    assign mem_wa = (otp_vld | eep_vld) ? ld_wa : sp_addr[`ECL_MEM_AW-1:0];
    assign mem_wd = otp_vld ? otp_data : (eep_vld ? eep_data : sp_wdata);
    // fault flag as it stands after this edge, keeps the status pin in step
    assign next_crc_fail = soft_rst ? 1'b0 :
        ((state == ST_WAIT) & eep_done) ? !eep_crc_pass : crc_fail;

    ecl_regmem u_mem (
        .clock(clock),
        .wr_en(mem_we),
        .wr_addr(mem_wa),
        .wr_data(mem_wd),
        .rd_addr(sp_addr[`ECL_MEM_AW-1:0]),
        .rd_data(mem_q)
    );

    //////////////////////////////////////////////////////////////////////
    // load sequencer
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= ST_OTP;
            cnt <= 7'h00;
            crc_fail <= 1'b0;
            otp_vld <= 1'b0;
            eep_vld <= 1'b0;
            otp_rd <= 1'b0;
            eep_rd <= 1'b0;
            otp_addr <= 6'h00;
            eep_addr <= 6'h00;
            ld_wa <= 6'h00;
            load_busy <= 1'b1;
        end else if (soft_rst) begin
            // pin reset restarts the load and clears the fault
            state <= ST_OTP;
            cnt <= 7'h00;
            crc_fail <= 1'b0;
            otp_vld <= 1'b0;
            eep_vld <= 1'b0;
            otp_rd <= 1'b0;
            eep_rd <= 1'b0;
            otp_addr <= 6'h00;
            eep_addr <= 6'h00;
            ld_wa <= 6'h00;
            load_busy <= 1'b1;
        end else begin
            ld_wa <= eep_rd ? eep_addr : otp_addr;
            otp_vld <= otp_rd;
            eep_vld <= eep_rd;
            otp_rd <= 1'b0;
            eep_rd <= 1'b0;
            case (state)
                ST_OTP: begin
                    // otp load runs independent of eeprom result
                    if (otp_load_en && cnt != `ECL_OTP_WORDS) begin
                        otp_rd <= 1'b1;
                        otp_addr <= cnt[`ECL_MEM_AW-1:0];
                        cnt <= cnt + 7'h01;
                    end else if (!otp_vld) begin
                        cnt <= 7'h00;
                        state <= ST_EEP;
                    end
                end
                ST_EEP: begin
                    // after a failed load the otp words were reapplied; eeprom is not read again
                    if (!eeprom_load_en || !eep_present || crc_fail) begin
                        state <= ST_RUN;
                        load_busy <= 1'b0;
                    end else if (cnt != `ECL_EEP_WORDS) begin
                        eep_rd <= 1'b1;
                        eep_addr <= cnt[`ECL_MEM_AW-1:0];
                        cnt <= cnt + 7'h01;
                    end else begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (eep_done) begin
                        crc_fail <= !eep_crc_pass;
                        if (!eep_crc_pass && otp_load_en) begin
                            // corrupt eeprom words were written; load otp again
                            cnt <= 7'h00;
                            state <= ST_OTP;
                        end else begin
                            state <= ST_RUN;
                            load_busy <= 1'b0;
                        end
                    end
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
                default: begin
                    state <= ST_OTP;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////
    // serial port answers
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sp_wr_ack <= 1'b0;
            rd_pend <= 1'b0;
            rd_gis <= 1'b0;
            rd_hit <= 1'b0;
            gis <= `ECL_GIS_RESERVED;
        end else begin
            sp_wr_ack <= (state == ST_RUN) & sp_wr & !crc_fail & !soft_rst;
            rd_pend <= (state == ST_RUN) & sp_rd & !soft_rst;
            rd_gis <= (sp_addr == `ECL_GIS_ADDR);
            rd_hit <= sp_mem_hit;
            gis <= `ECL_GIS_RESERVED;
            gis[`ECL_GIS_CRC_OK_BIT] <= !crc_fail;
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sp_rd_valid <= 1'b0;
            sp_rdata <= 8'h00;
        end else begin
            sp_rd_valid <= rd_pend;
            if (!rd_pend || crc_fail) begin
                sp_rdata <= 8'h00;
            end else if (rd_gis) begin
                sp_rdata <= gis;
            end else if (rd_hit) begin
                sp_rdata <= mem_q;
            end else begin
                sp_rdata <= 8'h00;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // status outputs
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            eeprom_crc_ok_n <= 1'b1;
            synth_mode <= 1'b1;
        end else begin
            eeprom_crc_ok_n <= !next_crc_fail;
            if (soft_rst) begin
                synth_mode <= 1'b1;
            end else if (mem_we && ({10'h000, mem_wa} == `ECL_MODE_ADDR)) begin
                // mode word zero selects crystal-only synthesis
                synth_mode <= (mem_wd == `ECL_MODE_SYNTH);
            end
        end
    end
endmodule

/* bench/ecl_props.sv */
// checker for the loader serial port and fault flag
module ecl_props (
    // clock and resets
    input wire logic clock, rstn, device_reset_in_n,
    // serial port and status
    input wire logic load_busy, sp_wr, sp_rd, sp_wr_ack, sp_rd_valid, eeprom_crc_ok_n,
    input wire logic [7:0] sp_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_wr_refused: assert property (sp_wr && !eeprom_crc_ok_n |=> !sp_wr_ack)
        else $error("write completed in failed state");
    a_rd_zero: assert property (sp_rd_valid && !eeprom_crc_ok_n |-> sp_rdata == 8'h00)
        else $error("nonzero read in failed state");
    a_fault_sticky: assert property (!eeprom_crc_ok_n && device_reset_in_n |=> !eeprom_crc_ok_n)
        else $error("fault cleared without reset");
    a_rdata_idle: assert property (!sp_rd_valid |-> sp_rdata == 8'h00)
        else $error("read data without valid");
    a_wr_ack: assert property (sp_wr && eeprom_crc_ok_n && !load_busy && device_reset_in_n |=> sp_wr_ack)
        else $error("write not acked");
    a_rd_answer: assert property (sp_rd && !load_busy && device_reset_in_n |-> ##2 sp_rd_valid)
        else $error("read not answered");
endmodule
bind ecl_loader ecl_props ecl_props_i (.*);

/* bench/ecl_src_model.sv */
// otp and eeprom source model facing the loader
module ecl_src_model (
    // loader side
    input wire logic clock, otp_rd, eep_rd, crc_bad,
    input wire logic [5:0] otp_addr, eep_addr,
    output logic [7:0] otp_data, eep_data,
    output logic eep_done, eep_crc_pass
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last = 1'b0;
    initial begin
        {otp_data, eep_data, eep_done, eep_crc_pass} = 18'h0;
    end
    // released data lines toggle instead of holding
    always @(posedge clock) begin
        otp_data <= otp_rd ? (otp_addr == 6'h0 ? 8'h00 : {2'h1, otp_addr}) : ~otp_data;
        eep_data <= eep_rd ? (eep_addr == 6'h0 ? {7'h0, crc_bad} : {2'h2, eep_addr}) : ~eep_data;
        last <= eep_rd && eep_addr == 6'h3f;
        eep_done <= last;
        eep_crc_pass <= last ? !crc_bad : ~eep_crc_pass;
    end
endmodule

/* bench/ecl_loader_tb.sv */
// self-checking bench for the configuration loader
module ecl_loader_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rstn = 0, device_reset_in_n = 1, otp_load_en = 1, eeprom_load_en = 1;
    logic eep_present = 1, crc_bad = 0, sp_wr = 0, sp_rd = 0;
    logic [15:0] sp_addr = 16'h0;
    logic [7:0] sp_wdata = 8'h0, otp_data, eep_data, sp_rdata;
    logic [5:0] otp_addr, eep_addr;
    logic otp_rd, eep_rd, eep_done, eep_crc_pass, sp_wr_ack, sp_rd_valid, load_busy, eeprom_crc_ok_n, synth_mode;
    int fails = 0, n_compared = 0;
    ecl_loader ecl_loader_i (.*);
    ecl_src_model ecl_src_model_i (.*);
    task chk(input string what, input logic [7:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task report_and_stop;
        $display("fails %0d compared %0d", fails, n_compared);
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task boot(input logic bad, pres, otp_en, eep_en);
        int i;
        @(posedge clock) device_reset_in_n <= 1'b0;
        crc_bad <= bad;
        eep_present <= pres;
        otp_load_en <= otp_en;
        eeprom_load_en <= eep_en;
        @(posedge clock) device_reset_in_n <= 1'b1;
        @(posedge clock);
        for (i = 0; i < 1000 && load_busy !== 1'b0; i++) @(posedge clock);
        chk("load busy", 8'h0, load_busy);
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d, input logic ack);
        @(posedge clock) sp_wr <= 1'b1;
        sp_addr <= a;
        sp_wdata <= d;
        @(posedge clock) sp_wr <= 1'b0;
        #1 chk("write ack", {7'h0, ack}, sp_wr_ack);
    endtask
    task rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clock) sp_rd <= 1'b1;
        sp_addr <= a;
        @(posedge clock) sp_rd <= 1'b0;
        @(posedge clock) #1 chk("read valid", 8'h1, sp_rd_valid);
        chk("read data", exp, sp_rdata);
    endtask
    task t_pass;
        boot(1'b0, 1'b1, 1'b1, 1'b1);
        chk("crc ok flag", 8'h1, eeprom_crc_ok_n);
        rd(16'h021f, 8'h01);
        wr(16'h0005, 8'ha5, 1'b1);
        wr(16'h0145, 8'h5a, 1'b1);
        rd(16'h0005, 8'ha5);
        rd(16'h0105, 8'h00);
        rd(16'h0001, 8'h81);
        chk("synth mode", 8'h1, synth_mode);
    endtask
    task t_fail;
        boot(1'b1, 1'b1, 1'b1, 1'b1);
        chk("crc ok flag", 8'h0, eeprom_crc_ok_n);
        rd(16'h021f, 8'h00);
        wr(16'h0005, 8'ha5, 1'b0);
        rd(16'h0001, 8'h00);
        chk("synth mode", 8'h1, synth_mode);
    endtask
    task t_absent;
        boot(1'b0, 1'b0, 1'b1, 1'b1);
        rd(16'h021f, 8'h01);
        rd(16'h0001, 8'h41);
    endtask
    task t_noload;
        boot(1'b0, 1'b1, 1'b0, 1'b0);
        rd(16'h021f, 8'h01);
        wr(16'h0006, 8'h3c, 1'b1);
        rd(16'h0006, 8'h3c);
        chk("synth mode", 8'h1, synth_mode);
        wr(16'h0000, 8'h01, 1'b1);
        chk("synth mode", 8'h0, synth_mode);
        wr(16'h0000, 8'h00, 1'b1);
        chk("synth mode", 8'h1, synth_mode);
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        report_and_stop;
    end
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        t_pass;
        t_fail;
        t_pass;
        t_absent;
        t_noload;
        report_and_stop;
    end
endmodule
